// file: design/drc_map.vh
`ifndef DRC_MAP_VH
`define DRC_MAP_VH
// Register offsets (byte addresses, one word each)
`define DRC_REG_CTRL 8'h00
`define DRC_REG_CMD 8'h04
`define DRC_REG_STAT 8'h08
`define DRC_REG_PEND 8'h0c
// Control register fields
`define DRC_CTRL_RSTMASK 0
`define DRC_CTRL_IRQMASK 1
`define DRC_CTRL_FOURPIN 2
`define DRC_CTRL_RESET 3'h3
// Command register fields (write one to act)
`define DRC_CMD_BREAK 0
`define DRC_CMD_RUN 1
`define DRC_CMD_STEP 2
`define DRC_CMD_DBGRST 3
// Status register fields
`define DRC_STAT_STATE_LO 0
`define DRC_STAT_HALT 2
`define DRC_STAT_DSTOP 3
`define DRC_STAT_DROP 4
`define DRC_STAT_READY 5
// Link preparation waits
`define DRC_WAIT_1PIN_MS 140
`define DRC_WAIT_4PIN_MS 5
`define DRC_CLK_HZ 10000000
`define DRC_WAIT_1PIN_CYC (`DRC_WAIT_1PIN_MS * (`DRC_CLK_HZ / 1000))
`define DRC_WAIT_4PIN_CYC (`DRC_WAIT_4PIN_MS * (`DRC_CLK_HZ / 1000))
`endif

// file: design/drc_run_ctrl.v
// Behaviour
// - User and target resets are blocked while the core single steps.
// - User resets raised in break or step are dropped, never replayed.
// - Debugger reset always applies regardless of reset masking.
// - After debugger reset every CPU enters break.
// - Interrupts to the core are masked during break or step.
// - During free run interrupts pass unchanged only while the IRQ mask bit is clear; with it set the pending latch drives them.
// - Masked maskable, fast and float interrupts stay pending until acknowledged while unmasked or cleared by a pending register write.
// - Handler-entry breakpoint hit in free run breaks at handler start.
// - A break request releases the core from halt.
// - Halt during single step breaks at next instruction instead.
// - Deep stop during single step breaks at reset address instead.
`include "drc_map.vh"
`timescale 1ns/100ps
`default_nettype none
module drc_run_ctrl #(
	parameter NCPU = 2,
	parameter NIRQ = 3,
	parameter [31:0] WAIT_1PIN = `DRC_WAIT_1PIN_CYC,
	parameter [31:0] WAIT_4PIN = `DRC_WAIT_4PIN_CYC
) (
	// Clock and reset
	input wire SYS_CLK_I,
	input wire SYS_RST_I,
	// Register port
	input wire [7:0] ADDR_I,
	input wire [31:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [31:0] RDATA_O,
	// Reset sources
	input wire PIN_RST_I,
	input wire SW_RST_I,
	output wire CORE_RST_O,
	// Interrupt requests: external_maskable, fast_external, float_exception
	input wire [NIRQ-1:0] IRQ_I,
	output wire [NIRQ-1:0] IRQ_O,
	input wire [NIRQ-1:0] IRQ_ACK_I,
	// Core run status
	input wire BP_HIT_I,
	input wire RETIRE_I,
	input wire HALT_INSN_I,
	input wire DSTOP_INSN_I,
	input wire WAKE_I,
	output wire HALT_O,
	output wire DSTOP_O,
	output wire [NCPU-1:0] CPU_BREAK_O,
	output wire RUN_EN_O,
	output wire REDIRECT_RST_O
);
	localparam ST_RUN = 2'h0;
	localparam ST_BRK = 2'h1;
	localparam ST_STEP = 2'h2;

	reg [1:0] st_q, st_d;
	reg [2:0] ctrl_q;
	reg halt_q, halt_d;
	reg dstop_q, dstop_d;
	reg drop_q, drop_d;
	reg dbg_rst_q;
	reg redir_q, redir_d;
	reg [31:0] wait_q;
	reg [NIRQ-1:0] pend_q;
	reg pin_s1_q, pin_s2_q;
	reg [NIRQ-1:0] irq_s1_q, irq_s2_q;

	wire wr_ctrl = WR_I && (ADDR_I == `DRC_REG_CTRL);
	wire wr_cmd = WR_I && (ADDR_I == `DRC_REG_CMD);
	wire wr_pend = WR_I && (ADDR_I == `DRC_REG_PEND);
	wire cmd_brk = wr_cmd && WDATA_I[`DRC_CMD_BREAK];
	wire cmd_run = wr_cmd && WDATA_I[`DRC_CMD_RUN];
	wire cmd_step = wr_cmd && WDATA_I[`DRC_CMD_STEP];
	wire cmd_rst = wr_cmd && WDATA_I[`DRC_CMD_DBGRST];
	wire in_dbg = (st_q != ST_RUN);
	wire user_rst = pin_s2_q | SW_RST_I;
	// Stepping and break always mask; free run honours reset mask bit
	wire rst_block = in_dbg | ctrl_q[`DRC_CTRL_RSTMASK];
	wire irq_mask = in_dbg;
	wire irq_bypass = !ctrl_q[`DRC_CTRL_IRQMASK] && !in_dbg;
	reg [NIRQ-1:0] irq_route;
	reg [31:0] wait_limit;
	wire link_ready;
	wire [31:0] stat_word;

	// Debug reset wins over every mask setting
	assign CORE_RST_O = dbg_rst_q | (user_rst & ~rst_block);
	assign IRQ_O = irq_route;
	assign HALT_O = halt_q;
	assign DSTOP_O = dstop_q;

	// Masked cores see nothing; the pending latch keeps requests
	always @* begin
		irq_route = pend_q;
		if (irq_mask) begin
			irq_route = {NIRQ{1'b0}};
		end else if (irq_bypass) begin
			irq_route = irq_s2_q;
		end
	end

	genvar c;
	generate
		for (c = 0; c < NCPU; c = c + 1) begin : g_cpu
			// Every core shares the one break state
			assign CPU_BREAK_O[c] = (st_q == ST_BRK);
		end
	endgenerate

	always @* begin
		if (ctrl_q[`DRC_CTRL_FOURPIN]) begin
			wait_limit = WAIT_4PIN;
		end else begin
			wait_limit = WAIT_1PIN;
		end
	end
	assign link_ready = (wait_q >= wait_limit);
	assign stat_word = {26'h0, link_ready, drop_q, dstop_q, halt_q, st_q};
	assign RUN_EN_O = (st_q != ST_BRK) && !halt_q && !dstop_q;
	assign REDIRECT_RST_O = redir_q;

	always @* begin
		st_d = st_q;
		halt_d = halt_q;
		dstop_d = dstop_q;
		redir_d = 1'b0;
		drop_d = drop_q;
		if (wr_pend && WDATA_I[8]) begin
			drop_d = 1'b0;
		end
		// A new drop beats the clear in the same cycle
		if (user_rst && in_dbg) begin
			drop_d = 1'b1;
		end
		case (st_q)
			ST_RUN: begin
				if (cmd_brk || BP_HIT_I) begin
					// Handler entry breakpoint stops before its first insn
					st_d = ST_BRK;
					halt_d = 1'b0;
				end else if (HALT_INSN_I) begin
					halt_d = 1'b1;
				end else if (DSTOP_INSN_I) begin
					dstop_d = 1'b1;
				end else if (WAKE_I) begin
					halt_d = 1'b0;
					dstop_d = 1'b0;
				end
				if (cmd_brk) begin
					dstop_d = 1'b0;
				end
			end
			ST_BRK: begin
				if (cmd_step) begin
					st_d = ST_STEP;
				end else if (cmd_run) begin
					st_d = ST_RUN;
				end
			end
			ST_STEP: begin
				if (DSTOP_INSN_I) begin
					st_d = ST_BRK;
					redir_d = 1'b1;
				end else if (HALT_INSN_I || RETIRE_I || cmd_brk) begin
					st_d = ST_BRK;
				end
			end
			default: begin
				st_d = ST_BRK;
			end
		endcase
		if (dbg_rst_q) begin
			st_d = ST_BRK;
			halt_d = 1'b0;
			dstop_d = 1'b0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NIRQ; g = g + 1) begin : g_pend
			// Request pins are asynchronous to this clock
			always @(posedge SYS_CLK_I) begin
				if (SYS_RST_I) begin
					irq_s1_q[g] <= 1'b0;
					irq_s2_q[g] <= 1'b0;
				end else begin
					irq_s1_q[g] <= IRQ_I[g];
					irq_s2_q[g] <= irq_s1_q[g];
				end
			end
			always @(posedge SYS_CLK_I) begin
				if (SYS_RST_I) begin
					pend_q[g] <= 1'b0;
				end else begin
					// Arrival beats acknowledge in the same cycle
					if (irq_s2_q[g]) begin
						pend_q[g] <= 1'b1;
					end else if (IRQ_ACK_I[g] && !irq_mask) begin
						pend_q[g] <= 1'b0;
					end else if (wr_pend && WDATA_I[g]) begin
						pend_q[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Reset pin comes from the board, so two stages first
	always @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end else begin
			pin_s1_q <= PIN_RST_I;
			pin_s2_q <= pin_s1_q;
		end
	end

	always @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			st_q <= ST_RUN;
			halt_q <= 1'b0;
			dstop_q <= 1'b0;
			redir_q <= 1'b0;
			dbg_rst_q <= 1'b0;
		end else begin
			st_q <= st_d;
			halt_q <= halt_d;
			dstop_q <= dstop_d;
			redir_q <= redir_d;
			dbg_rst_q <= cmd_rst;
		end
	end

	always @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			ctrl_q <= `DRC_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= WDATA_I[2:0];
		end
	end

	// Sticky drop flag, cleared only by software
	always @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			drop_q <= 1'b0;
		end else begin
			drop_q <= drop_d;
		end
	end

	// Advisory only: the core is not held, software polls the flag
	// before it resets itself or enters deep stop
	always @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			wait_q <= 32'h0;
		end else if (dbg_rst_q) begin
			wait_q <= 32'h0;
		end else if (wait_q != 32'hffffffff) begin
			wait_q <= wait_q + 32'h1;
		end
	end

	// Read data stand one cycle only, zero otherwise
	always @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			RDATA_O <= 32'h0;
		end else if (RD_I) begin
			case (ADDR_I)
				`DRC_REG_CTRL: begin
					RDATA_O <= {29'h0, ctrl_q};
				end
				`DRC_REG_STAT: begin
					RDATA_O <= stat_word;
				end
				`DRC_REG_PEND: begin
					RDATA_O <= {{(32-NIRQ){1'b0}}, pend_q};
				end
				default: begin
					RDATA_O <= 32'h0;
				end
			endcase
		end else begin
			RDATA_O <= 32'h0;
		end
	end
endmodule
`default_nettype wire

// file: dv/drc_emu.sv
`timescale 1ns/100ps
`default_nettype none
module drc_emu (
	// Debugger register access
	input wire logic clk_i,
	input wire logic [31:0] rdata_i,
	output logic [7:0] addr_o = 8'h00,
	output logic [31:0] wdata_o = 32'h0,
	output logic wr_o = 1'b0,
	output logic rd_o = 1'b0
);
	// Only used after reset release, so the link never meets held reset
	// Breaks are only commanded, never set before a reset instruction
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask
endmodule
`default_nettype wire

// file: dv/drc_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "drc_map.vh"
module drc_props #(parameter NCPU = 2, parameter NIRQ = 3) (
	// Watched ports
	input wire logic SYS_CLK_I, SYS_RST_I, WR_I, RD_I, SW_RST_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I, RDATA_O,
	input wire logic [NIRQ-1:0] IRQ_O,
	input wire logic [NCPU-1:0] CPU_BREAK_O,
	input wire logic CORE_RST_O, HALT_O, RUN_EN_O, REDIRECT_RST_O
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	wire logic cmd = WR_I && ADDR_I == `DRC_REG_CMD;
	sequence s_dbg; cmd && WDATA_I[3]; endsequence
	sequence s_brk; cmd && WDATA_I[3:0] == 4'h1; endsequence
	a_dbg_rst_on: assert property (s_dbg |=> CORE_RST_O)
		else $error("debugger reset lost");
	a_rst_all_break: assert property (s_dbg |=> ##1 &CPU_BREAK_O)
		else $error("no break after debugger reset");
	a_brk_stops_run: assert property (s_brk |=> &CPU_BREAK_O && !RUN_EN_O)
		else $error("break command ignored");
	a_irq_masked: assert property (|CPU_BREAK_O |-> IRQ_O == '0)
		else $error("interrupt passed in break");
	// A pulse one cycle after a debugger reset is legal, so skip it
	a_user_drop: assert property (|CPU_BREAK_O && SW_RST_I &&
		!$past(cmd) |-> !CORE_RST_O) else $error("user reset in break");
	a_rd_idle: assert property (!$past(RD_I) |-> RDATA_O == '0)
		else $error("read data outside its cycle");
	a_halt_wake: assert property ((HALT_O and s_brk) |-> ##[1:2] !HALT_O)
		else $error("break kept halt");
	a_redir_pulse: assert property (REDIRECT_RST_O |=> !REDIRECT_RST_O)
		else $error("redirect longer than a cycle");
endmodule
bind drc_run_ctrl drc_props #(.NCPU(NCPU), .NIRQ(NIRQ)) drc_props_i (
	.SYS_CLK_I, .SYS_RST_I, .WR_I, .RD_I, .SW_RST_I, .ADDR_I, .WDATA_I,
	.RDATA_O, .IRQ_O, .CPU_BREAK_O, .CORE_RST_O, .HALT_O, .RUN_EN_O,
	.REDIRECT_RST_O);
`default_nettype wire

// file: dv/drc_run_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "drc_map.vh"
module drc_run_ctrl_tb;
	logic clk = 1'b0, rst = 1'b1, sw = 1'b0, halt = 1'b0;
	logic pin = 1'b0, dstop = 1'b0, dst_o, run_en, redir;
	logic [2:0] irq = 3'h0, irq_o;
	logic [1:0] brk;
	logic [31:0] rdata, wdata, v;
	logic [7:0] addr;
	logic wr, rd, core_rst, hlt;
	int err_total = 0, checked = 0;
	drc_emu drc_emu_i (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	drc_run_ctrl #(.WAIT_1PIN(20), .WAIT_4PIN(5)) drc_run_ctrl_i (
		.SYS_CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PIN_RST_I(pin),
		.SW_RST_I(sw), .CORE_RST_O(core_rst), .IRQ_I(irq), .IRQ_O(irq_o),
		.IRQ_ACK_I(3'h0), .BP_HIT_I(1'b0), .RETIRE_I(halt),
		.HALT_INSN_I(halt), .DSTOP_INSN_I(dstop), .WAKE_I(1'b0),
		.HALT_O(hlt), .DSTOP_O(dst_o), .CPU_BREAK_O(brk),
		.RUN_EN_O(run_en), .REDIRECT_RST_O(redir));
	initial forever #50 clk = ~clk;
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task summarize;
		if (err_total == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task t_regs;
		drc_emu_i.rd(`DRC_REG_CTRL, v);
		chk("ctrl", 32'h3, v);
		drc_emu_i.rd(8'h10, v);
		chk("unmapped", 32'h0, v);
	endtask
	task t_irq;
		drc_emu_i.wr(`DRC_REG_CMD, 32'h1);
		irq <= 3'h7;
		repeat (4) @(posedge clk);
		irq <= 3'h0;
		#1 chk("irq_brk", 32'h0, irq_o);
		drc_emu_i.rd(`DRC_REG_PEND, v);
		chk("pend", 32'h7, v[2:0]);
		drc_emu_i.wr(`DRC_REG_CMD, 32'h2);
		#1 chk("irq_run", 32'h7, irq_o);
	endtask
	task t_drop;
		drc_emu_i.wr(`DRC_REG_CMD, 32'h1);
		drc_emu_i.wr(`DRC_REG_CMD, 32'h4);
		sw <= 1'b1;
		@(posedge clk);
		#1 chk("rst_step", 32'h0, core_rst);
		@(posedge clk);
		sw <= 1'b0;
		drc_emu_i.rd(`DRC_REG_STAT, v);
		chk("drop", 32'h1, v[4]);
		chk("stepping", 32'h2, v[1:0]);
		drc_emu_i.wr(`DRC_REG_PEND, 32'h100);
		drc_emu_i.rd(`DRC_REG_STAT, v);
		chk("drop_clr", 32'h0, v[4]);
		halt <= 1'b1;
		@(posedge clk);
		halt <= 1'b0;
		drc_emu_i.wr(`DRC_REG_CMD, 32'h2);
		#1 chk("no_replay", 32'h0, core_rst);
	endtask
	task t_dbg;
		drc_emu_i.wr(`DRC_REG_CMD, 32'h8);
		#1 chk("dbg_rst", 32'h1, core_rst);
		@(posedge clk);
		#1 chk("all_brk", 32'h3, brk);
	endtask
	task t_halt;
		drc_emu_i.wr(`DRC_REG_CMD, 32'h2);
		halt <= 1'b1;
		@(posedge clk);
		halt <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("halt", 32'h1, hlt);
		chk("halt_stop", 32'h0, run_en);
		drc_emu_i.wr(`DRC_REG_CMD, 32'h1);
		@(posedge clk);
		#1 chk("wake", 32'h0, hlt);
		drc_emu_i.wr(`DRC_REG_CMD, 32'h4);
		halt <= 1'b1;
		@(posedge clk);
		halt <= 1'b0;
		#1 chk("step_halt", 32'h0, hlt);
		chk("step_brk", 32'h3, brk);
		drc_emu_i.wr(`DRC_REG_CMD, 32'h4);
		dstop <= 1'b1;
		@(posedge clk);
		dstop <= 1'b0;
		#1 chk("redirect", 32'h1, redir);
		chk("no_dstop", 32'h0, dst_o);
		chk("dstop_brk", 32'h3, brk);
	endtask
	task t_link;
		drc_emu_i.wr(`DRC_REG_CTRL, 32'h4);
		drc_emu_i.wr(`DRC_REG_CMD, 32'h8);
		drc_emu_i.rd(`DRC_REG_STAT, v);
		chk("wait_4pin", 32'h0, v[5]);
		repeat (8) @(posedge clk);
		drc_emu_i.rd(`DRC_REG_STAT, v);
		chk("ready_4pin", 32'h1, v[5]);
		drc_emu_i.wr(`DRC_REG_CTRL, 32'h0);
		drc_emu_i.rd(`DRC_REG_STAT, v);
		chk("wait_1pin", 32'h0, v[5]);
		repeat (8) @(posedge clk);
		drc_emu_i.rd(`DRC_REG_STAT, v);
		chk("ready_1pin", 32'h1, v[5]);
		// Software runs and resets itself only once the link is ready
		drc_emu_i.wr(`DRC_REG_CMD, 32'h2);
		#1 chk("free_run", 32'h1, run_en);
		chk("irq_direct", 32'h0, irq_o);
		irq <= 3'h5;
		repeat (3) @(posedge clk);
		#1 chk("irq_pass", 32'h5, irq_o);
		irq <= 3'h0;
		sw <= 1'b1;
		@(posedge clk);
		#1 chk("sw_rst_run", 32'h1, core_rst);
		sw <= 1'b0;
		pin <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("pin_rst_run", 32'h1, core_rst);
		pin <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	initial begin
		#200000;
		err_total++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_irq();
		t_drop();
		t_dbg();
		t_halt();
		t_link();
		summarize();
	end
endmodule
`default_nettype wire
